// file: core/dau_bitrev.sv
// Bit-reversed address step: reverse-carry add of the modifier to the word
// index of a data address.
// Assumes the modifier holds half the buffer size in words.
module dau_bitrev
  import dau_pkg::*;
(
  input  wire logic [15:0] addr,
  input  wire logic [14:0] modifier,
  output logic      [15:0] next_addr,
  output logic             mod_ok
);

  logic [14:0] rev_sum;
  logic [14:0] one_hot_chk;

  // ----------------------------------------------------------------------
  // Reverse-carry add
  // ----------------------------------------------------------------------
  // Carries run toward bit 0, so bits above the buffer never change
  always_comb begin
    rev_sum   = dau_rev15(addr[15:1]) + dau_rev15(modifier);
    next_addr = {dau_rev15(rev_sum), addr[0]};
  end

  // Only a single set bit is a legal modifier
  always_comb begin
    one_hot_chk = modifier & (modifier - 15'h0001);
    mod_ok      = (modifier != 15'h0000) && (one_hot_chk == 15'h0000);
  end

endmodule : dau_bitrev

// file: core/dau_pkg.sv
// Types of the data address unit: operations and the grouped request and
// answer carriers that pass between the unit and the execution core.
// Assumes one core clock shared by all parties.
package dau_pkg;

  // --------------------------------------------------------------------
  // Address operations
  // --------------------------------------------------------------------
  typedef enum logic [3:0] {
    dau_op_idle, dau_op_read, dau_op_direct13, dau_op_direct16,
    dau_op_push, dau_op_pop, dau_op_call_lo, dau_op_call_hi,
    dau_op_exc_lo, dau_op_exc_hi, dau_op_bitrev
  } dau_op_t;

  typedef enum logic [1:0] {
    dau_ld_word, dau_ld_byte, dau_ld_sext, dau_ld_zext
  } dau_ld_t;

  // --------------------------------------------------------------------
  // Carriers
  // --------------------------------------------------------------------
  typedef struct packed {
    logic        valid;
    dau_op_t     op;
    logic [15:0] ea;
    logic        sp_rel;
    logic        table_op;
    logic        short_class;
    logic        in_repeat;
    logic [3:0]  rep_flags;
    logic [23:0] pc;
    logic [7:0]  status_low_byte;
    logic [15:0] push_data;
  } dau_req_t;

  typedef struct packed {
    logic        valid;
    logic [15:0] data_addr;
    logic        prog_access;
    logic [23:0] prog_addr;
    logic        x_space;
    logic [1:0]  extra_cycles;
    logic        mem_write;
    logic [15:0] wdata;
    logic        stack_trap;
  } dau_rsp_t;

  typedef struct packed {
    logic        valid;
    dau_ld_t     kind;
    logic        from_prog;
    logic [15:0] mem_data;
    logic [23:0] prog_word;
    logic [15:0] old_value;
  } dau_ld_req_t;

  typedef struct packed {
    logic        valid;
    logic [15:0] value;
  } dau_ld_rsp_t;

  function automatic logic [14:0] dau_rev15(input logic [14:0] v);
    logic [14:0] r;
    r = '0;
    for (int i = 0; i < 15; i++) begin
      r[i] = v[14 - i];
    end
    return r;
  endfunction : dau_rev15

endpackage : dau_pkg

// file: core/dau_regs.svh
// Constants of the data address unit: register offsets, field positions,
// reset values and address bounds.
// Assumes inclusion by bare name from the core/ folder.
`ifndef DAU_REGS_SVH
`define DAU_REGS_SVH

// ----------------------------------------------------------------------
// Register byte offsets on the AHB-Lite slave
// ----------------------------------------------------------------------
`define DAU_OFS_CTRL     8'h00
`define DAU_OFS_PAGE     8'h04
`define DAU_OFS_LIMIT    8'h08
`define DAU_OFS_BREV_MOD 8'h0c
`define DAU_OFS_SP       8'h10
`define DAU_OFS_STATUS   8'h14

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define DAU_CTRL_MAP_BIT     0
`define DAU_CTRL_BREV_BIT    1
`define DAU_STAT_OVF_BIT     0
`define DAU_STAT_UNF_BIT     1
`define DAU_STAT_LIMV_BIT    2

// ----------------------------------------------------------------------
// Reset values and address bounds
// ----------------------------------------------------------------------
`define DAU_CTRL_RESET   2'h0
`define DAU_PAGE_RESET   8'h00
`define DAU_BREV_MOD_RESET 15'h0000
`define DAU_SP_RESET     16'h0800
`define DAU_SFR_TOP      16'h0800
`define DAU_NEAR_MASK    16'h1fff
`define DAU_WORD_STEP    16'h0002

`endif

// file: core/dau_top.sv
// Data address unit: program space mapping, stack pointer with limit and
// underflow traps, direct and bit-reversed addressing, load merging,
// and an AHB-Lite register slave.
// Assumes the execution core and the bus share the single core clock.
`include "dau_regs.svh"

// Function
// - Map upper data half onto program page
// - Map only when EA msb and enable set
// - Program address: page above 15 EA bits
// - Return low 16 bits of program word
// - Upper data half always X space
// - Table ops suspend program space mapping
// - Outside repeat: one or two extra cycles
// - Repeat edges two extra, others none
// - Byte load keeps destination high byte
// - Sign and zero extend operations
// - Thirteen-bit direct field reaches near space
// - Sixteen-bit direct field for moves
// - Stack grows up, post-inc push, pre-dec pop
// - Call push clears upper stacked byte
// - Exception push carries status low byte
// - Limit unreset, bit zero reads zero
// - Push past equal limit traps
// - Stack address below 0x0800 traps
// - Bit-reverse mirrors address bit order
// - Modifier is half buffer, power of two
module dau_top
  import dau_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        rst_b,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire dau_req_t    req,
  output dau_rsp_t         rsp,
  input  wire dau_ld_req_t ld_req,
  output dau_ld_rsp_t      ld_rsp
);

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  logic [1:0]  core_control_register;
  logic [7:0]  program_page_select;
  logic [15:0] stack_limit_register;
  logic        limit_valid;
  logic [14:0] bit_reverse_modifier;
  logic [15:0] stack_pointer_register;
  logic        ovf_seen;
  logic        unf_seen;

  logic        dp_write;
  logic [7:0]  dp_ofs;
  logic        addr_phase;
  logic [31:0] wr_val;
  logic [31:0] rd_val;

  logic [15:0] next_ea;
  logic [15:0] next_sp;
  logic [15:0] next_wdata;
  logic        next_mem_write;
  logic        next_prog;
  logic [1:0]  next_extra;
  logic        next_ovf;
  logic        next_unf;
  logic        sp_used;
  logic [15:0] brev_addr;
  logic        brev_ok;
  logic [15:0] ld_src;

  function automatic logic is_ofs(input logic [7:0] a, input logic [7:0] b);
    return a == b;
  endfunction : is_ofs

  // ----------------------------------------------------------------------
  // AHB-Lite slave
  // ----------------------------------------------------------------------
  // Zero wait states; read data is fetched in the address phase and a
  // write still in its data phase is forwarded, except a STATUS clear and an SP write lost to a stack op.
  assign addr_phase = hsel && htrans[1] && hready;
  assign wr_val     = hwdata;

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      dp_write <= 1'b0;
      dp_ofs   <= 8'h00;
    end else begin
      dp_write <= addr_phase && hwrite;
      dp_ofs   <= haddr[7:0];
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      hreadyout <= 1'b0;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  always_comb begin
    rd_val = 32'h0000_0000;
    if (is_ofs(haddr[7:0], `DAU_OFS_CTRL)) begin
      rd_val[1:0] = core_control_register;
    end else if (is_ofs(haddr[7:0], `DAU_OFS_PAGE)) begin
      rd_val[7:0] = program_page_select;
    end else if (is_ofs(haddr[7:0], `DAU_OFS_LIMIT)) begin
      rd_val[15:0] = {stack_limit_register[15:1], 1'b0};
    end else if (is_ofs(haddr[7:0], `DAU_OFS_BREV_MOD)) begin
      rd_val[14:0] = bit_reverse_modifier;
    end else if (is_ofs(haddr[7:0], `DAU_OFS_SP)) begin
      rd_val[15:0] = stack_pointer_register;
    end else if (is_ofs(haddr[7:0], `DAU_OFS_STATUS)) begin
      rd_val[`DAU_STAT_OVF_BIT]  = ovf_seen;
      rd_val[`DAU_STAT_UNF_BIT]  = unf_seen;
      rd_val[`DAU_STAT_LIMV_BIT] = limit_valid;
    end
    // Forward only the bits that the register keeps; status flags are not forwarded
    if (dp_write && is_ofs(dp_ofs, haddr[7:0])) begin
      if (is_ofs(dp_ofs, `DAU_OFS_CTRL)) begin
        rd_val = {30'h0, wr_val[1:0]};
      end else if (is_ofs(dp_ofs, `DAU_OFS_PAGE)) begin
        rd_val = {24'h0, wr_val[7:0]};
      end else if (is_ofs(dp_ofs, `DAU_OFS_LIMIT)) begin
        rd_val = {16'h0000, wr_val[15:1], 1'b0};
      end else if (is_ofs(dp_ofs, `DAU_OFS_BREV_MOD)) begin
        rd_val = {17'h0, wr_val[14:0]};
      end else if (is_ofs(dp_ofs, `DAU_OFS_SP) && next_sp == stack_pointer_register) begin
        rd_val = {16'h0000, wr_val[15:1], 1'b0};
      end
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      hrdata <= 32'h0000_0000;
    end else if (addr_phase && !hwrite) begin
      hrdata <= rd_val;
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      core_control_register <= `DAU_CTRL_RESET;
      program_page_select   <= `DAU_PAGE_RESET;
      bit_reverse_modifier  <= `DAU_BREV_MOD_RESET;
    end else if (dp_write) begin
      if (is_ofs(dp_ofs, `DAU_OFS_CTRL)) begin
        core_control_register <= wr_val[1:0];
      end else if (is_ofs(dp_ofs, `DAU_OFS_PAGE)) begin
        program_page_select <= wr_val[7:0];
      end else if (is_ofs(dp_ofs, `DAU_OFS_BREV_MOD)) begin
        bit_reverse_modifier <= wr_val[14:0];
      end
    end
  end

  // Limit has no reset value; overflow checks wait for the first write
  always_ff @(posedge clock) begin
    if (dp_write && is_ofs(dp_ofs, `DAU_OFS_LIMIT)) begin
      stack_limit_register <= {wr_val[15:1], 1'b0};
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      limit_valid <= 1'b0;
    end else if (dp_write && is_ofs(dp_ofs, `DAU_OFS_LIMIT)) begin
      limit_valid <= 1'b1;
    end
  end

  // ----------------------------------------------------------------------
  // Stack pointer
  // ----------------------------------------------------------------------
  assign sp_used = req.valid && (req.sp_rel || req.op == dau_op_push ||
                   req.op == dau_op_pop || req.op == dau_op_call_lo ||
                   req.op == dau_op_call_hi || req.op == dau_op_exc_lo ||
                   req.op == dau_op_exc_hi);

  always_comb begin
    next_sp = stack_pointer_register;
    if (req.valid) begin
      case (req.op)
        dau_op_push, dau_op_call_lo, dau_op_call_hi,
        dau_op_exc_lo, dau_op_exc_hi: begin
          next_sp = stack_pointer_register + `DAU_WORD_STEP;
        end
        dau_op_pop: begin
          next_sp = stack_pointer_register - `DAU_WORD_STEP;
        end
        default: begin
          next_sp = stack_pointer_register;
        end
      endcase
    end
  end

  // A software write loses to a stack operation in the same cycle
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      stack_pointer_register <= `DAU_SP_RESET;
    end else if (req.valid && next_sp != stack_pointer_register) begin
      stack_pointer_register <= next_sp;
    end else if (dp_write && is_ofs(dp_ofs, `DAU_OFS_SP)) begin
      stack_pointer_register <= {wr_val[15:1], 1'b0};
    end
  end

  // ----------------------------------------------------------------------
  // Effective address and write data
  // ----------------------------------------------------------------------
  dau_bitrev u_bitrev (
    .addr      (req.ea),
    .modifier  (bit_reverse_modifier),
    .next_addr (brev_addr),
    .mod_ok    (brev_ok)
  );

  always_comb begin
    next_ea        = req.ea;
    next_wdata     = req.push_data;
    next_mem_write = 1'b0;
    case (req.op)
      dau_op_direct13: begin
        next_ea = req.ea & `DAU_NEAR_MASK;
      end
      dau_op_direct16: begin
        next_ea = req.ea;
      end
      dau_op_push: begin
        next_ea        = stack_pointer_register;
        next_mem_write = 1'b1;
      end
      dau_op_pop: begin
        next_ea = stack_pointer_register - `DAU_WORD_STEP;
      end
      dau_op_call_lo, dau_op_exc_lo: begin
        next_ea        = stack_pointer_register;
        next_wdata     = req.pc[15:0];
        next_mem_write = 1'b1;
      end
      dau_op_call_hi: begin
        next_ea        = stack_pointer_register;
        next_wdata     = {8'h00, req.pc[23:16]};
        next_mem_write = 1'b1;
      end
      dau_op_exc_hi: begin
        next_ea        = stack_pointer_register;
        next_wdata     = {req.status_low_byte, req.pc[23:16]};
        next_mem_write = 1'b1;
      end
      dau_op_bitrev: begin
        if (core_control_register[`DAU_CTRL_BREV_BIT] && brev_ok) begin
          next_ea = brev_addr;
        end
      end
      default: begin
        next_ea = req.ea;
      end
    endcase
  end

  // ----------------------------------------------------------------------
  // Program space mapping and extra cycles
  // ----------------------------------------------------------------------
  // Mapped accesses are reads only; a write to the upper half stays in X
  always_comb begin
    next_prog = next_ea[15] && core_control_register[`DAU_CTRL_MAP_BIT] &&
                !req.table_op && !next_mem_write;
    next_extra = 2'd0;
    if (next_prog) begin
      if (!req.in_repeat) begin
        next_extra = req.short_class ? 2'd1 : 2'd2;
      end else if (req.rep_flags != 4'h0) begin
        next_extra = 2'd2;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Stack faults
  // ----------------------------------------------------------------------
  always_comb begin
    next_ovf = sp_used && next_mem_write && limit_valid &&
               (next_ea > stack_limit_register);
    next_unf = sp_used && (next_ea < `DAU_SFR_TOP);
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      rsp <= '0;
    end else begin
      rsp.valid        <= req.valid && req.op != dau_op_idle;
      rsp.data_addr    <= next_ea;
      rsp.prog_access  <= req.valid && next_prog;
      rsp.prog_addr    <= {1'b0, program_page_select, next_ea[14:0]};
      rsp.x_space      <= next_ea[15];
      rsp.extra_cycles <= req.valid ? next_extra : 2'd0;
      rsp.mem_write    <= req.valid && next_mem_write;
      rsp.wdata        <= next_wdata;
      rsp.stack_trap   <= next_ovf || next_unf;
    end
  end

  // Sticky fault flags; a new fault wins over a write-one clear
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      ovf_seen <= 1'b0;
      unf_seen <= 1'b0;
    end else begin
      if (next_ovf) begin
        ovf_seen <= 1'b1;
      end else if (dp_write && is_ofs(dp_ofs, `DAU_OFS_STATUS) &&
                   wr_val[`DAU_STAT_OVF_BIT]) begin
        ovf_seen <= 1'b0;
      end
      if (next_unf) begin
        unf_seen <= 1'b1;
      end else if (dp_write && is_ofs(dp_ofs, `DAU_OFS_STATUS) &&
                   wr_val[`DAU_STAT_UNF_BIT]) begin
        unf_seen <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Load merging
  // ----------------------------------------------------------------------
  assign ld_src = ld_req.from_prog ? ld_req.prog_word[15:0] : ld_req.mem_data;

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      ld_rsp <= '0;
    end else begin
      ld_rsp.valid <= ld_req.valid;
      case (ld_req.kind)
        dau_ld_byte: begin
          ld_rsp.value <= {ld_req.old_value[15:8], ld_src[7:0]};
        end
        dau_ld_sext: begin
          ld_rsp.value <= {{8{ld_req.old_value[7]}}, ld_req.old_value[7:0]};
        end
        dau_ld_zext: begin
          ld_rsp.value <= {8'h00, ld_req.old_value[7:0]};
        end
        default: begin
          ld_rsp.value <= ld_src;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  property p_map_gate;
    @(posedge clock) disable iff (!rst_b)
    rsp.prog_access |-> rsp.data_addr[15] && $past(!req.table_op) &&
                        $past(core_control_register[`DAU_CTRL_MAP_BIT]);
  endproperty
  a_map_gate: assert property (p_map_gate) else $error("bad mapping");

  property p_page;
    @(posedge clock) disable iff (!rst_b)
    rsp.prog_access |-> rsp.prog_addr[22:15] == $past(program_page_select) &&
                        rsp.prog_addr[14:0] == rsp.data_addr[14:0];
  endproperty
  a_page: assert property (p_page) else $error("bad program address");

  property p_xspace;
    @(posedge clock) disable iff (!rst_b)
    rsp.valid && $past(req.op) == dau_op_read |-> rsp.x_space == $past(req.ea[15]);
  endproperty
  a_xspace: assert property (p_xspace) else $error("bad x space");

  property p_extra;
    @(posedge clock) disable iff (!rst_b)
    req.valid && next_prog && !req.in_repeat && req.short_class
      |=> rsp.extra_cycles == 2'd1;
  endproperty
  a_extra: assert property (p_extra) else $error("bad extra count");

  property p_repeat;
    @(posedge clock) disable iff (!rst_b)
    req.valid && next_prog && req.in_repeat && req.rep_flags == 4'h0
      |=> rsp.extra_cycles == 2'd0;
  endproperty
  a_repeat: assert property (p_repeat) else $error("bad repeat count");

  property p_byte;
    @(posedge clock) disable iff (!rst_b)
    ld_req.valid && ld_req.kind == dau_ld_byte
      |=> ld_rsp.value[15:8] == $past(ld_req.old_value[15:8]);
  endproperty
  a_byte: assert property (p_byte) else $error("byte load hit high byte");

  property p_push;
    @(posedge clock) disable iff (!rst_b)
    req.valid && req.op == dau_op_push
      |=> stack_pointer_register == $past(stack_pointer_register) + 16'h0002 &&
          rsp.data_addr == $past(stack_pointer_register);
  endproperty
  a_push: assert property (p_push) else $error("bad push");

  property p_call;
    @(posedge clock) disable iff (!rst_b)
    req.valid && req.op == dau_op_call_hi |=> rsp.wdata[15:8] == 8'h00;
  endproperty
  a_call: assert property (p_call) else $error("call byte not clear");

  property p_unf;
    @(posedge clock) disable iff (!rst_b)
    sp_used && next_ea < 16'h0800 |=> rsp.stack_trap && unf_seen;
  endproperty
  a_unf: assert property (p_unf) else $error("missed underflow");

endmodule : dau_top

// file: tb/data_address_unit_bench.sv
// Self-checking bench of the data address unit: AHB-Lite register
// tasks, core request tasks and load merge tasks.
// Assumes zero-wait bus answers and one-cycle registered core answers.
`include "dau_regs.svh"
`define DAU_CHK(a, e) begin checks_done++; if ((a) !== (e)) begin num_errors++; \
  $display("BAD t=%0t got %h exp %h", $time, a, e); end end
module data_address_unit_bench;
  import dau_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clock, rst_b, hsel, hwrite, hready, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [23:0] flash_word, pw;
  logic [15:0] a;
  logic [9:0]  tc [9];
  dau_req_t    req, nr;
  dau_rsp_t    rsp;
  dau_ld_req_t ld_req;
  dau_ld_rsp_t ld_rsp;
  int          num_errors, checks_done, cyc;
  assign hready = hreadyout;
  dau_top dut (.clock(clock), .rst_b(rst_b), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .req(req), .rsp(rsp), .ld_req(ld_req),
    .ld_rsp(ld_rsp));
  dau_flash_model flash (.prog_addr(rsp.prog_addr), .prog_word(flash_word));
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic complete_run;
    $display("errors %0d checks %0d", num_errors, checks_done);
    if (num_errors == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : complete_run
  task automatic bus(input logic w, input logic [7:0] ad, input logic [31:0] d);
    @(posedge clock);
    hsel <= 1'b1; htrans <= 2'b10; hwrite <= w; haddr <= {24'h0, ad};
    do @(posedge clock); while (hreadyout !== 1'b1);
    hsel <= 1'b0; htrans <= 2'b00; hwdata <= d;
    do @(posedge clock); while (hreadyout !== 1'b1);
    rd = hrdata;
    `DAU_CHK(hresp, 1'b0)
  endtask : bus
  task automatic op(input dau_op_t o, input logic [15:0] ea);
    nr.valid = 1'b1;
    nr.op = o;
    nr.ea = ea;
    @(posedge clock); req <= nr;
    @(posedge clock); req.valid <= 1'b0;
    #1;
    `DAU_CHK(rsp.valid, 1'b1)
  endtask : op
  task automatic ld(input dau_ld_t k, input logic fp, input logic [15:0] m,
                    input logic [23:0] w, input logic [15:0] old);
    @(posedge clock); ld_req <= '{1'b1, k, fp, m, w, old};
    @(posedge clock); ld_req.valid <= 1'b0;
    #1;
    `DAU_CHK(ld_rsp.valid, 1'b1)
  endtask : ld
  // ----------------------------------------------------------------
  // Clock and hang guard
  // ----------------------------------------------------------------
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  always @(posedge clock) begin
    cyc++;
    if (cyc == 5000) begin
      num_errors++;
      complete_run;
    end
  end
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    rst_b = 1'b0; hsel = 1'b0; haddr = '0; htrans = 2'b00; hwrite = 1'b0;
    hsize = 3'b010; hwdata = '0; req = '0; ld_req = '0; nr = '0;
    repeat (12) @(posedge clock);
    rst_b <= 1'b1;
    bus(0, `DAU_OFS_SP, 0); `DAU_CHK(rd, 32'h0000_0800)
    bus(1, `DAU_OFS_LIMIT, 32'h0803);
    bus(0, `DAU_OFS_LIMIT, 0); `DAU_CHK(rd, 32'h0000_0802)
    // Stack ops always come a bus cycle after a limit write
    nr.push_data = 16'hbeef;
    op(dau_op_push, 16'h0); `DAU_CHK({rsp.data_addr, rsp.wdata}, 32'h0800_beef)
    `DAU_CHK({rsp.mem_write, rsp.stack_trap}, 2'b10)
    op(dau_op_push, 16'h0); `DAU_CHK({rsp.data_addr, rsp.stack_trap}, 17'h0_1004)
    op(dau_op_push, 16'h0); `DAU_CHK({rsp.data_addr, rsp.stack_trap}, 17'h0_1009)
    op(dau_op_pop, 16'h0); `DAU_CHK(rsp.data_addr, 16'h0804)
    bus(1, `DAU_OFS_SP, 32'h0800);
    op(dau_op_pop, 16'h0); `DAU_CHK({rsp.data_addr, rsp.stack_trap}, 17'h0_0ffd)
    nr.sp_rel = 1'b1;
    op(dau_op_read, 16'h0700); `DAU_CHK(rsp.stack_trap, 1'b1)
    nr.sp_rel = 1'b0;
    bus(0, `DAU_OFS_STATUS, 0); `DAU_CHK(rd, 32'h7)
    bus(1, `DAU_OFS_STATUS, 32'h3);
    bus(0, `DAU_OFS_STATUS, 0); `DAU_CHK(rd, 32'h4)
    bus(0, 8'h18, 0); `DAU_CHK(rd, 32'h0)
    bus(1, `DAU_OFS_LIMIT, 32'h1ffe);
    bus(1, `DAU_OFS_SP, 32'h0900);
    nr.pc = 24'hab1234;
    nr.status_low_byte = 8'h5c;
    op(dau_op_call_lo, 16'h0); `DAU_CHK(rsp.wdata, 16'h1234)
    op(dau_op_call_hi, 16'h0); `DAU_CHK(rsp.wdata, 16'h00ab)
    op(dau_op_exc_hi, 16'h0); `DAU_CHK(rsp.wdata, 16'h5cab)
    // Mapped reads: {ea msb, table, short, repeat, edge flags, extra}
    tc = '{10'b1010000001, 10'b1000000010, 10'b1001000110, 10'b1001001010,
           10'b1001010010, 10'b1001100010, 10'b1001000000, 10'b1100000000,
           10'b0000000000};
    bus(1, `DAU_OFS_CTRL, 32'h1);
    bus(1, `DAU_OFS_PAGE, 32'h3c);
    for (int i = 0; i < 9; i++) begin
      nr.table_op = tc[i][8];
      nr.short_class = tc[i][7];
      nr.in_repeat = tc[i][6];
      nr.rep_flags = tc[i][5:2];
      op(dau_op_read, {tc[i][9], 15'h1234});
      `DAU_CHK(rsp.prog_access, tc[i][9] & ~tc[i][8])
      `DAU_CHK(rsp.x_space, tc[i][9])
      if (rsp.prog_access === 1'b1) begin
        `DAU_CHK(rsp.prog_addr, {1'b0, 8'h3c, 15'h1234})
        `DAU_CHK(rsp.extra_cycles, tc[i][1:0])
        pw = flash_word;
      end
    end
    nr = '0;
    bus(1, `DAU_OFS_CTRL, 32'h0);
    op(dau_op_read, 16'h9234); `DAU_CHK({rsp.prog_access, rsp.x_space}, 2'b01)
    ld(dau_ld_word, 1'b1, 16'h0, pw, 16'h0); `DAU_CHK(ld_rsp.value, pw[15:0])
    ld(dau_ld_byte, 1'b0, 16'h34cd, 24'h0, 16'hab12); `DAU_CHK(ld_rsp.value, 16'habcd)
    ld(dau_ld_sext, 1'b0, 16'h1234, 24'h0, 16'h0085); `DAU_CHK(ld_rsp.value, 16'hff85)
    ld(dau_ld_zext, 1'b0, 16'h0000, 24'h0, 16'h1285); `DAU_CHK(ld_rsp.value, 16'h0085)
    op(dau_op_direct13, 16'hff34); `DAU_CHK(rsp.data_addr, 16'h1f34)
    op(dau_op_direct16, 16'hff34); `DAU_CHK(rsp.data_addr, 16'hff34)
    // Sixteen-entry buffer: modifier is half the size in words
    bus(1, `DAU_OFS_CTRL, 32'h2);
    bus(1, `DAU_OFS_BREV_MOD, 32'h0008);
    a = 16'h0;
    foreach (tc[i]) begin
      if (i < 4) begin
        op(dau_op_bitrev, a);
        a = {11'h0, 4'({4'd8, 4'd4, 4'd12, 4'd2} >> (12 - 4 * i)), 1'b0};
        `DAU_CHK(rsp.data_addr, a)
      end
    end
    bus(1, `DAU_OFS_BREV_MOD, 32'h0003);
    op(dau_op_bitrev, 16'h0010); `DAU_CHK(rsp.data_addr, 16'h0010)
    complete_run;
  end
endmodule : data_address_unit_bench

// file: tb/dau_flash_model.sv
// Program flash seen by the data address unit on a mapped read.
// Assumes a combinational read; the word depends only on its address.
module dau_flash_model (
  input  wire logic [23:0] prog_addr,
  output logic      [23:0] prog_word
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------------------------------
  // Word contents
  // ----------------------------------------------------------------
  // Upper byte is an illegal-opcode filler; it must never reach data
  assign prog_word = {8'hff, prog_addr[15:0] ^ 16'h5a5a};
endmodule : dau_flash_model
